//--- core/ddc_pkg.sv
// shared constants, states and state record of the descriptor data channel
package ddc_pkg;
    localparam int DDC_WORD_W = 36;
    localparam int DDC_CNT_W = 18;
    localparam int DDC_PTR_W = 22;
    // bit n counted from the left sits at vector index 35-n
    localparam int DDC_NARROW_PTR_W = 18;
    localparam int DDC_WIDE_PTR_W = 22;
    localparam int DDC_NARROW_CNT_W = 18;
    localparam int DDC_WIDE_CNT_W = 14;
    localparam int DDC_HALF_W = 18;
    localparam int DDC_CLK_PERIOD_NS = 40;
    localparam int DDC_START_DELAY_NS = 50;
    localparam int DDC_START_DELAY_CYC =
        (DDC_START_DELAY_NS + DDC_CLK_PERIOD_NS - 1) / DDC_CLK_PERIOD_NS;
    localparam logic [1:0] DDC_START_DELAY_LAST = 2'(DDC_START_DELAY_CYC - 1);
    localparam logic [DDC_WORD_W-1:0] DDC_WORD_ZERO = 36'h0_0000_0000;
    localparam logic [DDC_PTR_W-1:0] DDC_PTR_ZERO = 22'h00_0000;
    localparam logic [DDC_CNT_W-1:0] DDC_CNT_ZERO = 18'h0_0000;
    localparam logic [DDC_CNT_W-1:0] DDC_CNT_ONES = 18'h3_FFFF;

    typedef enum logic [3:0] {
        DDC_IDLE = 4'h0,
        DDC_START_DLY = 4'h1,
        DDC_WAIT_ADDR = 4'h2,
        DDC_LOAD_ADDR = 4'h3,
        DDC_FETCH = 4'h4,
        DDC_EVAL = 4'h5,
        DDC_XFER_IN = 4'h6,
        DDC_IN_WRITE = 4'h7,
        DDC_XFER_OUT = 4'h8,
        DDC_OUT_READ = 4'h9
    } ddc_state_type;

    typedef struct packed {
        ddc_state_type state;
        logic [1:0] delay_cnt;
        logic start_s;
        logic start_prev;
        logic pulse_s;
        logic pulse_prev;
        logic to_peer;
        logic cycle_halt;
        logic [DDC_PTR_W-1:0] desc_ptr;
        logic [DDC_CNT_W-1:0] count;
        logic [DDC_PTR_W-1:0] xfer_ptr;
        logic [DDC_WORD_W-1:0] buffer;
        logic buf_full;
        logic buf_perr;
        logic dev_ready;
        logic skip;
        logic [DDC_WORD_W-1:0] data_out;
        logic data_oe;
        logic chan_pulse;
        logic desc_perr;
        logic data_perr;
    } ddc_regs_type;
endpackage

//--- core/ddc_eval_if.sv
// descriptor word and its split fields passed to the evaluator
`timescale 1ns/1ps
interface ddc_eval_if;
    import ddc_pkg::*;
    logic [DDC_WORD_W-1:0] word;
    logic wide;
    logic [DDC_CNT_W-1:0] count;
    logic [DDC_PTR_W-1:0] pointer;
    logic count_zero;
    logic pointer_zero;
    modport eval (input word, input wide, output count, output pointer,
        output count_zero, output pointer_zero);
    modport user (output word, output wide, input count, input pointer,
        input count_zero, input pointer_zero);
endinterface

//--- core/ddc_desc_eval.sv
// splits a descriptor into count and pointer by format and flags zero fields
`timescale 1ns/1ps
module ddc_desc_eval (
    ddc_eval_if.eval eval_port
);
    import ddc_pkg::*;

    always_comb begin
        if (eval_port.wide) begin
            eval_port.count = {{(DDC_CNT_W-DDC_WIDE_CNT_W){1'b1}},
                eval_port.word[DDC_WORD_W-1:DDC_WIDE_PTR_W]};
            eval_port.pointer = eval_port.word[DDC_WIDE_PTR_W-1:0];
            eval_port.count_zero = (eval_port.word[DDC_WORD_W-1:DDC_WIDE_PTR_W] == '0);
        end else begin
            eval_port.count = eval_port.word[DDC_WORD_W-1:DDC_NARROW_PTR_W];
            eval_port.pointer = {{(DDC_PTR_W-DDC_NARROW_PTR_W){1'b0}},
                eval_port.word[DDC_NARROW_PTR_W-1:0]};
            eval_port.count_zero = (eval_port.word[DDC_WORD_W-1:DDC_NARROW_PTR_W] == '0);
        end
        eval_port.pointer_zero = (eval_port.pointer == DDC_PTR_ZERO);
    end
endmodule

//--- core/ddc_channel.sv
// descriptor data channel sequencer: peripheral handshake, descriptor walk, word moves
`timescale 1ns/1ps
// How it works
// - descriptor parity fault drops grant and sends one descriptor fault pulse
// - faulty memory word goes out with its strobe and a payload fault pulse
// - either side ends a session; grant falls, request may stay up
// - request clears halt flag and buffer; grant rises after the 50 ns delay, rounded up to two 40 ns clocks
// - right half of buffer loads descriptor pointer, buffer cleared together
// - descriptor fetched at descriptor pointer; left is count, right pointer
// - both nonzero: move words, step count and pointer per word
// - count overflow fetches the next descriptor
// - nonzero count, zero pointer into memory: accept words, write none
// - zero count, nonzero pointer: jump to pointer and fetch again
// - all-zero descriptor returns channel to idle and drops grant
// - descriptor pointer steps once a transfer descriptor is evaluated
// - toward peripheral, first fetched word goes out at once
// - toward peripheral, empty buffer reads memory, full buffer waits strobe
// - toward peripheral, zero count and empty buffer fetch next descriptor
// - into memory with nonzero pointer, each strobed word is stored, stepped, then answered
// - descriptor split follows narrow or wide format
// - force clear returns the whole channel to cleared idle
module ddc_channel (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_force_clear,
    input wire logic i_wide_format,
    input wire logic i_start,
    input wire logic i_to_peer_direction,
    input wire logic i_dev_pulse,
    input wire logic [ddc_pkg::DDC_WORD_W-1:0] i_data,
    output logic [ddc_pkg::DDC_WORD_W-1:0] o_data,
    output logic o_data_oe,
    output logic o_busy,
    output logic o_chan_pulse,
    output logic o_desc_parity_err,
    output logic o_data_parity_err,
    output logic o_cycle_halt,
    output logic o_mem_req,
    output logic o_mem_we,
    output logic [ddc_pkg::DDC_PTR_W-1:0] o_mem_addr,
    output logic [ddc_pkg::DDC_WORD_W-1:0] o_mem_wdata,
    input wire logic i_mem_ack,
    input wire logic [ddc_pkg::DDC_WORD_W-1:0] i_mem_rdata,
    input wire logic i_mem_parity_err
);
    import ddc_pkg::*;

    ddc_regs_type r_q;
    ddc_regs_type r_d;
    ddc_eval_if eval_bus ();
    logic pulse_evt;
    logic [DDC_PTR_W-1:0] xfer_ptr_inc;
    logic [DDC_CNT_W-1:0] count_inc;
    logic count_last;

    localparam ddc_regs_type DDC_REGS_RESET = '{
        state: DDC_IDLE,
        delay_cnt: 2'h0,
        desc_ptr: DDC_PTR_ZERO,
        count: DDC_CNT_ZERO,
        xfer_ptr: DDC_PTR_ZERO,
        buffer: DDC_WORD_ZERO,
        data_out: DDC_WORD_ZERO,
        default: 1'b0
    };

    assign eval_bus.word = r_q.buffer;
    assign eval_bus.wide = i_wide_format;

    ddc_desc_eval u_eval (
        .eval_port(eval_bus)
    );

    // rising edge of the sampled strobe is the event
    assign pulse_evt = r_q.pulse_s & ~r_q.pulse_prev;
    assign count_inc = r_q.count + 18'h0_0001;
    assign count_last = (r_q.count == DDC_CNT_ONES);

    always_comb begin
        xfer_ptr_inc = r_q.xfer_ptr + 22'h00_0001;
        if (!i_wide_format) begin
            xfer_ptr_inc[DDC_PTR_W-1:DDC_NARROW_PTR_W] = '0;
        end
    end

    always_comb begin
        r_d = r_q;
        r_d.start_s = i_start;
        r_d.pulse_s = i_dev_pulse;
        r_d.pulse_prev = r_q.pulse_s;
        r_d.start_prev = r_q.start_s;
        r_d.chan_pulse = 1'b0;
        r_d.desc_perr = 1'b0;
        r_d.data_perr = 1'b0;
        r_d.data_oe = 1'b0;
        case (r_q.state)
            DDC_IDLE: begin
                // only a fresh request opens a session, a held one after termination does not
                if (r_q.start_s && !r_q.start_prev) begin
                    r_d.cycle_halt = 1'b0;
                    r_d.buffer = DDC_WORD_ZERO;
                    r_d.buf_full = 1'b0;
                    r_d.delay_cnt = 2'h0;
                    r_d.state = DDC_START_DLY;
                end
            end
            DDC_START_DLY: begin
                r_d.delay_cnt = r_q.delay_cnt + 2'h1;
                r_d.to_peer = i_to_peer_direction;
                if (r_q.delay_cnt == DDC_START_DELAY_LAST) begin
                    r_d.state = DDC_WAIT_ADDR;
                end
            end
            DDC_WAIT_ADDR: begin
                if (pulse_evt) begin
                    r_d.buffer = i_data;
                    r_d.state = DDC_LOAD_ADDR;
                end
            end
            DDC_LOAD_ADDR: begin
                r_d.desc_ptr = {{(DDC_PTR_W-DDC_HALF_W){1'b0}},
                    r_q.buffer[DDC_HALF_W-1:0]};
                r_d.buffer = DDC_WORD_ZERO;
                r_d.dev_ready = r_q.to_peer;
                r_d.state = DDC_FETCH;
            end
            DDC_FETCH: begin
                if (i_mem_ack) begin
                    r_d.buffer = i_mem_rdata;
                    if (i_mem_parity_err) begin
                        r_d.desc_perr = 1'b1;
                        r_d.cycle_halt = 1'b1;
                        r_d.state = DDC_IDLE;
                    end else begin
                        r_d.state = DDC_EVAL;
                    end
                end
            end
            DDC_EVAL: begin
                if (eval_bus.count_zero && eval_bus.pointer_zero) begin
                    r_d.cycle_halt = 1'b1;
                    r_d.state = DDC_IDLE;
                end else if (eval_bus.count_zero) begin
                    r_d.desc_ptr = eval_bus.pointer;
                    r_d.state = DDC_FETCH;
                end else begin
                    r_d.count = eval_bus.count;
                    r_d.xfer_ptr = eval_bus.pointer;
                    r_d.skip = eval_bus.pointer_zero & ~r_q.to_peer;
                    r_d.desc_ptr = r_q.desc_ptr + 22'h00_0001;
                    if (!i_wide_format) begin
                        r_d.desc_ptr[DDC_PTR_W-1:DDC_NARROW_PTR_W] = '0;
                    end
                    r_d.buffer = DDC_WORD_ZERO;
                    r_d.buf_full = 1'b0;
                    if (r_q.to_peer) begin
                        r_d.state = DDC_XFER_OUT;
                    end else begin
                        r_d.chan_pulse = 1'b1;
                        r_d.state = DDC_XFER_IN;
                    end
                end
            end
            DDC_XFER_IN: begin
                if (pulse_evt) begin
                    r_d.buffer = i_data;
                    if (r_q.skip) begin
                        r_d.count = count_inc;
                        r_d.buffer = DDC_WORD_ZERO;
                        r_d.chan_pulse = 1'b1;
                        if (count_last) begin
                            r_d.state = DDC_FETCH;
                        end
                    end else begin
                        r_d.state = DDC_IN_WRITE;
                    end
                end
            end
            DDC_IN_WRITE: begin
                if (i_mem_ack) begin
                    r_d.count = count_inc;
                    r_d.xfer_ptr = xfer_ptr_inc;
                    r_d.buffer = DDC_WORD_ZERO;
                    r_d.chan_pulse = 1'b1;
                    r_d.state = count_last ? DDC_FETCH : DDC_XFER_IN;
                end
            end
            DDC_XFER_OUT: begin
                if (pulse_evt) begin
                    r_d.dev_ready = 1'b1;
                end
                if (r_q.buf_full && r_q.dev_ready) begin
                    r_d.data_out = r_q.buffer;
                    r_d.data_oe = 1'b1;
                    r_d.chan_pulse = 1'b1;
                    r_d.data_perr = r_q.buf_perr;
                    r_d.buf_full = 1'b0;
                    r_d.buf_perr = 1'b0;
                    r_d.dev_ready = pulse_evt;
                end else if (!r_q.buf_full) begin
                    if (r_q.count == DDC_CNT_ZERO) begin
                        r_d.state = DDC_FETCH;
                    end else begin
                        r_d.state = DDC_OUT_READ;
                    end
                end
            end
            DDC_OUT_READ: begin
                if (pulse_evt) begin
                    r_d.dev_ready = 1'b1;
                end
                if (i_mem_ack) begin
                    r_d.buffer = i_mem_rdata;
                    r_d.buf_perr = i_mem_parity_err;
                    r_d.buf_full = 1'b1;
                    r_d.count = count_inc;
                    r_d.xfer_ptr = xfer_ptr_inc;
                    r_d.state = DDC_XFER_OUT;
                end
            end
            default: begin
                r_d.state = DDC_IDLE;
            end
        endcase
        // peripheral withdrawing its request ends the session
        if (r_q.state != DDC_IDLE && !r_q.start_s) begin
            r_d.state = DDC_IDLE;
            r_d.data_perr = 1'b0;
            r_d.data_oe = 1'b0;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rstn || i_force_clear) begin
            r_q <= DDC_REGS_RESET;
        end else begin
            r_q <= r_d;
        end
    end

    // grant is up whenever the channel is past the start delay
    assign o_busy = (r_q.state != DDC_IDLE) && (r_q.state != DDC_START_DLY);
    assign o_mem_req = (r_q.state == DDC_FETCH) || (r_q.state == DDC_IN_WRITE)
        || (r_q.state == DDC_OUT_READ);
    assign o_mem_we = (r_q.state == DDC_IN_WRITE);
    assign o_mem_addr = (r_q.state == DDC_FETCH) ? r_q.desc_ptr : r_q.xfer_ptr;
    assign o_mem_wdata = r_q.buffer;
    assign o_data = r_q.data_out;
    assign o_data_oe = r_q.data_oe;
    assign o_chan_pulse = r_q.chan_pulse;
    assign o_desc_parity_err = r_q.desc_perr;
    assign o_data_parity_err = r_q.data_perr;
    assign o_cycle_halt = r_q.cycle_halt;
endmodule

//--- dv/ddc_channel_sva.sv
// concurrent checks on the channel ports
`timescale 1ns/1ps
module ddc_channel_sva (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_force_clear,
    input wire logic i_start,
    input wire logic i_mem_ack,
    input wire logic i_mem_parity_err,
    input wire logic o_busy,
    input wire logic o_chan_pulse,
    input wire logic o_data_oe,
    input wire logic o_desc_parity_err,
    input wire logic o_data_parity_err,
    input wire logic o_cycle_halt,
    input wire logic o_mem_req,
    input wire logic o_mem_we,
    input wire logic [ddc_pkg::DDC_PTR_W-1:0] o_mem_addr
);
    import ddc_pkg::*;
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rstn || i_force_clear);
    sequence grant_wait;
        ##1 !o_busy ##[1:3] o_busy;
    endsequence
    sequence word_answer;
        ##1 o_chan_pulse ##1 !o_chan_pulse;
    endsequence
    grant_delay_a: assert property ($rose(i_start) && !o_busy |-> grant_wait)
        else $error("grant not raised in time after request");
    halt_clear_a: assert property ($rose(i_start) && o_cycle_halt |-> ##[1:4] !o_cycle_halt)
        else $error("halt flag kept after new request");
    req_drop_a: assert property (o_busy && !i_start |-> ##[1:3] !o_busy)
        else $error("grant kept after request dropped");
    desc_err_a: assert property (o_desc_parity_err |-> $past(i_mem_ack) &&
        $past(i_mem_parity_err) && !o_busy && o_cycle_halt ##1 !o_desc_parity_err)
        else $error("descriptor fault pulse wrong");
    data_err_a: assert property (o_data_parity_err |-> o_chan_pulse && o_data_oe)
        else $error("payload fault pulse without word");
    out_pulse_a: assert property (o_data_oe |-> o_chan_pulse ##1 !o_data_oe)
        else $error("outgoing word strobe not single");
    write_ack_a: assert property (o_mem_req && o_mem_we && i_mem_ack |-> word_answer)
        else $error("stored word not answered");
    req_hold_a: assert property (o_mem_req && !i_mem_ack |=>
        !o_busy || (o_mem_req && $stable(o_mem_addr) && $stable(o_mem_we)))
        else $error("memory request changed before ack");
endmodule
bind ddc_channel ddc_channel_sva u_ddc_channel_sva (.i_clock, .i_rstn, .i_force_clear,
    .i_start, .i_mem_ack, .i_mem_parity_err, .o_busy, .o_chan_pulse, .o_data_oe,
    .o_desc_parity_err, .o_data_parity_err, .o_cycle_halt, .o_mem_req, .o_mem_we,
    .o_mem_addr);

//--- dv/ddc_peer_model.sv
// peripheral model: request, strobes and word exchange on the channel cable
`timescale 1ns/1ps
module ddc_peer_model (
    input wire logic i_clock,
    input wire logic i_busy,
    input wire logic i_chan_pulse,
    input wire logic [ddc_pkg::DDC_WORD_W-1:0] i_data,
    input wire logic i_data_perr,
    output logic o_start,
    output logic o_dir,
    output logic o_pulse,
    output logic [ddc_pkg::DDC_WORD_W-1:0] o_data
);
    import ddc_pkg::*;
    logic [DDC_WORD_W:0] rx_q[$];
    int lapses = 0;
    initial begin
        o_start = 1'b0;
        o_dir = 1'b0;
        o_pulse = 1'b0;
        o_data = DDC_WORD_ZERO;
    end
    always @(posedge i_clock) begin
        if (i_chan_pulse === 1'b1) begin
            rx_q.push_back({i_data_perr, i_data});
        end
    end
    task automatic wt(input logic v);
        int n;
        n = 0;
        while (i_busy !== v && n < 400) begin
            @(negedge i_clock);
            n++;
        end
        if (i_busy !== v) lapses++;
    endtask
    task automatic strobe(input logic [DDC_WORD_W-1:0] w);
        @(posedge i_clock);
        o_data <= w;
        o_pulse <= 1'b1;
        @(posedge i_clock);
        o_pulse <= 1'b0;
        repeat (3) @(posedge i_clock);
        o_data <= ~w;
    endtask
    task automatic take(input int k, output logic [DDC_WORD_W:0] e);
        int n;
        n = 0;
        e = 'x;
        while (rx_q.size() < k && n < 400) begin
            @(negedge i_clock);
            n++;
        end
        if (rx_q.size() < k) lapses++;
        else repeat (k) e = rx_q.pop_front();
    endtask
    // only device on the chain, so it keeps the grant it receives
    task automatic open(input logic d, input logic [7:0] p);
        rx_q.delete();
        @(posedge i_clock);
        o_start <= 1'b1;
        o_dir <= d;
        wt(1'b1);
        // lines 27-34 are vector bits 8:1, bit 0 and bits 9-35 stay zero
        strobe(36'({p, 1'b0}));
    endtask
    task automatic send(input logic [DDC_WORD_W-1:0] w, input int k);
        logic [DDC_WORD_W:0] e;
        take(k, e);
        strobe(w);
    endtask
    task automatic stop();
        @(posedge i_clock);
        o_start <= 1'b0;
        wt(1'b0);
        repeat (10) @(posedge i_clock);
    endtask
endmodule

//--- dv/ddc_channel_tb_top.sv
// testbench top: peripheral model, memory responder and channel sessions
`timescale 1ns/1ps
module ddc_channel_tb_top;
    import ddc_pkg::*;
    logic i_clock = 1'b0;
    logic i_rstn = 1'b0;
    logic i_force_clear = 1'b0;
    logic i_wide_format = 1'b0;
    logic i_mem_ack = 1'b0;
    logic i_mem_parity_err = 1'b0;
    logic [DDC_WORD_W-1:0] i_mem_rdata = DDC_WORD_ZERO;
    logic i_start, i_to_peer_direction, i_dev_pulse, o_data_oe, o_busy, o_chan_pulse;
    logic o_desc_parity_err, o_data_parity_err, o_cycle_halt, o_mem_req, o_mem_we;
    logic [DDC_WORD_W-1:0] i_data, o_data, o_mem_wdata;
    logic [DDC_PTR_W-1:0] o_mem_addr;
    logic [DDC_WORD_W-1:0] mem [0:255];
    logic [255:0] bad = '0;
    logic [DDC_WORD_W:0] e;
    int fails = 0;
    int tests_run = 0;
    int writes = 0;
    int desc_errs = 0;
    ddc_channel u_ddc_channel (.i_clock, .i_rstn, .i_force_clear, .i_wide_format, .i_start,
        .i_to_peer_direction, .i_dev_pulse, .i_data, .o_data, .o_data_oe, .o_busy,
        .o_chan_pulse, .o_desc_parity_err, .o_data_parity_err, .o_cycle_halt, .o_mem_req,
        .o_mem_we, .o_mem_addr, .o_mem_wdata, .i_mem_ack, .i_mem_rdata, .i_mem_parity_err);
    ddc_peer_model u_peer (.i_clock, .i_busy(o_busy), .i_chan_pulse(o_chan_pulse),
        .i_data(o_data), .i_data_perr(o_data_parity_err), .o_start(i_start),
        .o_dir(i_to_peer_direction), .o_pulse(i_dev_pulse), .o_data(i_data));
    initial begin
        forever #20 i_clock = ~i_clock;
    end
    // memory answers one cycle after each request; released data lines toggle
    always @(posedge i_clock) begin
        i_mem_ack <= o_mem_req && !i_mem_ack;
        i_mem_rdata <= (o_mem_req && !i_mem_ack) ? mem[o_mem_addr[7:0]] : ~i_mem_rdata;
        i_mem_parity_err <= o_mem_req && !i_mem_ack && bad[o_mem_addr[7:0]];
        if (i_mem_ack && o_mem_req && o_mem_we) begin
            mem[o_mem_addr[7:0]] <= o_mem_wdata;
            writes <= writes + 1;
        end
        if (o_desc_parity_err === 1'b1) desc_errs <= desc_errs + 1;
    end
    function automatic logic [35:0] nd(input int n, input logic [17:0] p);
        return {18'(-n), p};
    endfunction
    function automatic logic [35:0] wd(input int n, input logic [21:0] p);
        return {14'(-n), p};
    endfunction
    task automatic chk(input string what, input logic [DDC_WORD_W:0] exp, got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out();
        fails += u_peer.lapses;
        if (fails == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge i_clock);
        fails++;
        close_out();
    end
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = DDC_WORD_ZERO;
        mem[8'h20] = nd(0, 18'h0_0010);
        mem[8'h10] = nd(2, 18'h0_0040);
        mem[8'h11] = nd(1, 18'h0_0000);
        mem[8'h30] = wd(2, 22'h00_0040);
        mem[8'h50] = nd(1, 18'h0_0048);
        bad[8'h41] = 1'b1;
        bad[8'h50] = 1'b1;
        repeat (12) @(posedge i_clock);
        i_rstn <= 1'b1;
        @(negedge i_clock);
        chk("busy after reset", 37'h0, 37'(o_busy));
        u_peer.open(1'b0, 8'h10);
        u_peer.send(36'hA_0000_0001, 1);
        u_peer.send(36'hB_0000_0002, 1);
        u_peer.send(36'hC_0000_0003, 2);
        u_peer.take(1, e);
        u_peer.wt(1'b0);
        repeat (4) @(negedge i_clock);
        chk("no regrant", 37'h0, 37'(o_busy));
        chk("halt", 37'h1, 37'(o_cycle_halt));
        chk("word 0", 37'(36'hA_0000_0001), 37'(mem[8'h40]));
        chk("word 1", 37'(36'hB_0000_0002), 37'(mem[8'h41]));
        chk("writes", 37'h2, 37'(writes));
        u_peer.stop();
        i_wide_format <= 1'b1;
        u_peer.open(1'b1, 8'h18);
        chk("halt cleared", 37'h0, 37'(o_cycle_halt));
        u_peer.take(1, e);
        chk("out 0", {1'b0, 36'hA_0000_0001}, e);
        u_peer.strobe(DDC_WORD_ZERO);
        u_peer.take(1, e);
        chk("out 1", {1'b1, 36'hB_0000_0002}, e);
        u_peer.strobe(DDC_WORD_ZERO);
        u_peer.wt(1'b0);
        u_peer.stop();
        i_wide_format <= 1'b0;
        u_peer.open(1'b0, 8'h28);
        u_peer.wt(1'b0);
        repeat (4) @(negedge i_clock);
        chk("no regrant on fault", 37'h0, 37'(o_busy));
        chk("halt on fault", 37'h1, 37'(o_cycle_halt));
        u_peer.stop();
        chk("fault pulses", 37'h1, 37'(desc_errs));
        u_peer.open(1'b0, 8'h08);
        u_peer.stop();
        u_peer.open(1'b0, 8'h08);
        @(posedge i_clock);
        i_force_clear <= 1'b1;
        @(negedge i_clock);
        @(negedge i_clock);
        chk("busy on clear", 37'h0, 37'(o_busy));
        chk("req on clear", 37'h0, 37'(o_mem_req));
        u_peer.stop();
        i_force_clear <= 1'b0;
        close_out();
    end
endmodule
